// [common/ecc_report_pkg.sv]
package ecc_report_pkg;
  // register byte offsets on the control port
  localparam logic [9:0] OFS_STATUS      = 10'h000;
  localparam logic [9:0] OFS_IRQ_EN      = 10'h004;
  localparam logic [9:0] OFS_CHECK_EN    = 10'h008;
  localparam logic [9:0] OFS_CE_COUNT    = 10'h00c;
  localparam logic [9:0] OFS_CE_ADDR_LO  = 10'h1c0;
  localparam logic [9:0] OFS_CE_ADDR_HI  = 10'h1c4;
  // field positions
  localparam int BIT_UE = 0;
  localparam int BIT_CE = 1;
  localparam int BIT_CHECK_EN = 0;
  // widths and reset values
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 32;
  localparam int CNT_W     = 8;
  localparam int MEM_ADDR_W = 32;
  localparam logic [1:0]  RST_FLAGS   = 2'h0;
  localparam logic [1:0]  RST_IRQ_EN  = 2'h0;
  localparam logic [7:0]  RST_COUNT   = 8'h00;
  localparam logic [31:0] RST_ADDR    = 32'h0000_0000;
endpackage

// [rtl/ecc_ce_counter.sv]
`timescale 1ns/10ps
// saturating correctable-error counter with software load
module ecc_ce_counter #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  // control
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] load_val_i,
  input  wire logic             inc_i,
  // state
  output logic      [WIDTH-1:0] count_o
);
  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } cnt_state_t;

  cnt_state_t st_q;
  cnt_state_t st_d;

  // next count: load beats increment, increment stops at all ones
  always_comb begin
    st_d = st_q;
    if (load_i) begin
      st_d.cnt = load_val_i;
    end else if (inc_i && (st_q.cnt != {WIDTH{1'b1}})) begin
      st_d.cnt = st_q.cnt + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q.cnt <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign count_o = st_q.cnt;

  a_count_no_wrap: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!load_i && st_q.cnt == {WIDTH{1'b1}}) |=> st_q.cnt == {WIDTH{1'b1}})
    else $error("counter wrapped past maximum");
endmodule

// [rtl/ecc_error_report_regs.sv]
`timescale 1ns/10ps
module ecc_error_report_regs
#(
  parameter bit ECC_EN                   = 1'b1,
  parameter bit check_enable_reset_param = 1'b1
) (
  // clock and reset
  input  wire logic                                mclk_i,
  input  wire logic                                rst_n_i,
  // control port register access
  input  wire logic                                reg_wr_i,
  input  wire logic                                reg_rd_i,
  input  wire logic [ecc_report_pkg::ADDR_W-1:0]   reg_addr_i,
  input  wire logic [ecc_report_pkg::DATA_W-1:0]   reg_wdata_i,
  output logic      [ecc_report_pkg::DATA_W-1:0]   reg_rdata_o,
  // error events from the read-path decoder
  input  wire logic                                ce_event_i,
  input  wire logic                                ue_event_i,
  input  wire logic [ecc_report_pkg::MEM_ADDR_W-1:0] err_addr_i,
  // outputs to the data path and system
  output logic                                     check_enable_o,
  output logic                                     irq_o
);
  import ecc_report_pkg::*;

  typedef struct packed {
    logic                  ce_flag;
    logic                  uncorrected_flag;
    logic                  ce_irq_en;
    logic                  uncorrected_irq_enable;
    logic                  check_en;
    logic                  capture_armed;
    logic [MEM_ADDR_W-1:0] corrected_first_addr;
    logic [DATA_W-1:0]     rdata;
    logic                  irq;
  } regs_state_t;

  regs_state_t st_q;
  regs_state_t st_d;

  logic [CNT_W-1:0] corrected_count;
  logic             wr_status;
  logic             wr_irq_en;
  logic             wr_check;
  logic             wr_count;
  logic             check_live;
  logic             ce_seen;
  logic             ue_seen;
  logic             rd_mapped;

  // compare a register offset against the bus address
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // write strobes per register
  // fixed low offsets
  assign wr_status = reg_wr_i && hit(reg_addr_i, OFS_STATUS);
  assign wr_irq_en = reg_wr_i && hit(reg_addr_i, OFS_IRQ_EN);
  assign wr_check  = reg_wr_i && hit(reg_addr_i, OFS_CHECK_EN);
  assign wr_count  = reg_wr_i && hit(reg_addr_i, OFS_CE_COUNT) && ECC_EN;

  // errors only count while read checking is live
  // no ecc, no check
  assign check_live = ECC_EN && st_q.check_en;
  assign ce_seen    = check_live && ce_event_i;
  assign ue_seen    = check_live && ue_event_i;

  // reads that land on a backed register
  assign rd_mapped = hit(reg_addr_i, OFS_STATUS) || hit(reg_addr_i, OFS_IRQ_EN)
                  || hit(reg_addr_i, OFS_CHECK_EN) || hit(reg_addr_i, OFS_CE_COUNT)
                  || hit(reg_addr_i, OFS_CE_ADDR_LO);

  // correctable counter
  // eight bit counter
  ecc_ce_counter #(
    .WIDTH (CNT_W)
  ) u_ce_counter (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (wr_count),
    .load_val_i (reg_wdata_i[CNT_W-1:0]),
    .inc_i      (ce_seen),
    .count_o    (corrected_count)
  );

  // next-state logic for all registers except the correctable count, which steps in u_ce_counter
  always_comb begin
    st_d = st_q;
    if (wr_status && reg_wdata_i[BIT_CE]) begin
      st_d.ce_flag = 1'b0;
    end
    if (wr_status && reg_wdata_i[BIT_UE]) begin
      st_d.uncorrected_flag = 1'b0;
    end
    if (wr_status && reg_wdata_i[BIT_CE]) begin
      st_d.capture_armed = 1'b1;
    end
    if (ce_seen) begin
      st_d.ce_flag = 1'b1;
    end
    if (ue_seen) begin
      st_d.uncorrected_flag = 1'b1;
    end
    if (ce_seen && st_q.capture_armed) begin
      st_d.corrected_first_addr = err_addr_i;
      st_d.capture_armed        = 1'b0;
    end
    // interrupt enables
    if (wr_irq_en) begin
      st_d.ce_irq_en              = reg_wdata_i[BIT_CE];
      st_d.uncorrected_irq_enable = reg_wdata_i[BIT_UE];
    end
    if (wr_check && ECC_EN) begin
      st_d.check_en = reg_wdata_i[BIT_CHECK_EN];
    end
    if (!ECC_EN) begin
      st_d.ce_flag                = 1'b0;
      st_d.uncorrected_flag       = 1'b0;
      st_d.ce_irq_en              = 1'b0;
      st_d.uncorrected_irq_enable = 1'b0;
      st_d.check_en               = 1'b0;
      st_d.corrected_first_addr   = RST_ADDR;
    end
    st_d.irq = (st_d.ce_flag && st_d.ce_irq_en)
            || (st_d.uncorrected_flag && st_d.uncorrected_irq_enable);
    // read data, registered
    st_d.rdata = '0;
    if (reg_rd_i && ECC_EN) begin
      unique case (reg_addr_i)
        OFS_STATUS: begin
          st_d.rdata[BIT_CE] = st_q.ce_flag;
          st_d.rdata[BIT_UE] = st_q.uncorrected_flag;
        end
        OFS_IRQ_EN: begin
          st_d.rdata[BIT_CE] = st_q.ce_irq_en;
          st_d.rdata[BIT_UE] = st_q.uncorrected_irq_enable;
        end
        OFS_CHECK_EN: begin
          st_d.rdata[BIT_CHECK_EN] = st_q.check_en;
        end
        OFS_CE_COUNT: begin
          st_d.rdata[CNT_W-1:0] = corrected_count;
        end
        OFS_CE_ADDR_LO: begin
          st_d.rdata = st_q.corrected_first_addr;
        end
        default: begin
          st_d.rdata = '0;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q.ce_flag                <= RST_FLAGS[BIT_CE];
      st_q.uncorrected_flag       <= RST_FLAGS[BIT_UE];
      st_q.ce_irq_en              <= RST_IRQ_EN[BIT_CE];
      st_q.uncorrected_irq_enable <= RST_IRQ_EN[BIT_UE];
      st_q.check_en               <= ECC_EN && check_enable_reset_param;
      st_q.capture_armed          <= 1'b1;
      st_q.corrected_first_addr   <= RST_ADDR;
      st_q.rdata                  <= '0;
      st_q.irq                    <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata_o    = st_q.rdata;
  assign irq_o          = st_q.irq;
  assign check_enable_o = st_q.check_en;

  // checks on the register behaviour
  // ce flag sets
  a_ce_flag_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_seen |=> st_q.ce_flag)
    else $error("correctable flag not set");

  a_ce_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_q.ce_flag && !(wr_status && reg_wdata_i[BIT_CE])) |=> st_q.ce_flag)
    else $error("correctable flag dropped without a clear");

  a_ue_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (st_q.uncorrected_flag && !(wr_status && reg_wdata_i[BIT_UE]))
      |=> st_q.uncorrected_flag)
    else $error("uncorrected flag dropped without a clear");

  a_ue_flag_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ue_seen && !st_q.uncorrected_irq_enable) |=> st_q.uncorrected_flag)
    else $error("uncorrected flag not set when masked");

  a_w1c_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (wr_status && reg_wdata_i[BIT_CE] && !ce_seen) |=> !st_q.ce_flag)
    else $error("write one did not clear");

  a_ue_w1c: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (wr_status && reg_wdata_i[BIT_UE] && !ue_seen) |=> !st_q.uncorrected_flag)
    else $error("write one did not clear uncorrected flag");

  a_no_write_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!st_q.uncorrected_flag && !ue_seen) |=> !st_q.uncorrected_flag)
    else $error("flag set without error");

  a_ce_no_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!st_q.ce_flag && !ce_seen) |=> !st_q.ce_flag)
    else $error("correctable flag set without error");

  a_irq_value: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ##1 irq_o == ((st_q.ce_flag && st_q.ce_irq_en)
                 || (st_q.uncorrected_flag && st_q.uncorrected_irq_enable)))
    else $error("interrupt mismatch");

  a_irq_en_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (wr_irq_en && ECC_EN) |=> (st_q.ce_irq_en == $past(reg_wdata_i[BIT_CE]))
      && (st_q.uncorrected_irq_enable == $past(reg_wdata_i[BIT_UE])))
    else $error("interrupt enable write lost");

  a_irq_masked: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!st_q.ce_irq_en && !st_q.uncorrected_irq_enable) |-> !irq_o)
    else $error("interrupt with enables clear");

  a_ue_irq_masked: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!st_q.uncorrected_irq_enable && !(st_q.ce_flag && st_q.ce_irq_en)) |-> !irq_o)
    else $error("masked uncorrected flag drove interrupt");

  a_no_ecc_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !ECC_EN |-> (reg_rdata_o == '0) && !irq_o)
    else $error("registers visible without ecc");

  a_no_ecc_check: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !ECC_EN |-> !check_enable_o)
    else $error("checking enabled without ecc");

  a_check_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (wr_check && ECC_EN) |=> check_enable_o == $past(reg_wdata_i[BIT_CHECK_EN]))
    else $error("check enable write lost");

  a_check_off_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!st_q.check_en && !st_q.ce_flag && !(wr_count)) |=> !st_q.ce_flag)
    else $error("error recorded with checking off");

  a_addr_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!st_q.capture_armed && !wr_status) |=> $stable(st_q.corrected_first_addr))
    else $error("capture overwritten while disarmed");

  a_addr_capture: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_seen && st_q.capture_armed) |=> st_q.corrected_first_addr == $past(err_addr_i)
      ##0 !st_q.capture_armed)
    else $error("first address not captured");

  a_count_step: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (ce_seen && !wr_count && (corrected_count != {CNT_W{1'b1}}))
      |=> corrected_count == $past(corrected_count) + CNT_W'(1))
    else $error("count did not step on correctable error");

  a_count_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (!ce_seen && !wr_count) |=> $stable(corrected_count))
    else $error("count moved without error or write");

  a_count_load: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr_count |=> corrected_count == $past(reg_wdata_i[CNT_W-1:0]))
    else $error("count write lost");

  a_status_read: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (reg_rd_i && (reg_addr_i == OFS_STATUS))
      |=> reg_rdata_o == {30'h0, $past(st_q.ce_flag), $past(st_q.uncorrected_flag)})
    else $error("status read layout wrong");

  a_addr_hi_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (reg_rd_i && (reg_addr_i == OFS_CE_ADDR_HI)) |=> reg_rdata_o == '0)
    else $error("upper address half not zero");

  a_resv_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (reg_rd_i && !rd_mapped) |=> reg_rdata_o == '0)
    else $error("reserved offset read not zero");

  // main scenarios reached
  c_ce_event: cover property (@(posedge mclk_i) disable iff (!rst_n_i) ce_seen);
  c_irq_rise: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(irq_o));
  c_rearm: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    !st_q.capture_armed ##1 st_q.capture_armed);
  c_set_clear: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_seen && wr_status && reg_wdata_i[BIT_CE]);
  c_count_sat: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    ce_seen && (corrected_count == {CNT_W{1'b1}}));
endmodule

// [tb/err_src_model.sv]
`timescale 1ns/10ps
// read-path decoder stand-in: one-cycle error pulses with the access address
module err_src_model (
  // clock
  input  wire logic        mclk_i,
  // error events
  output logic             ce_o,
  output logic             ue_o,
  output logic [31:0]      addr_o
);
  // quiet outputs from time zero
  initial begin
    ce_o = 1'b0;
    ue_o = 1'b0;
    addr_o = 32'h0;
  end
  // one pulse per call; address scrambled once the pulse is over
  task automatic hit(input logic ce, input logic ue, input logic [31:0] a);
    @(negedge mclk_i);
    ce_o = ce;
    ue_o = ue;
    addr_o = a;
    @(negedge mclk_i);
    ce_o = 1'b0;
    ue_o = 1'b0;
    addr_o = ~a;
  endtask
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
  import ecc_report_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [9:0]  addr = 10'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rdata0;
  logic [31:0] eaddr;
  logic        ce;
  logic        ue;
  logic        chk_en;
  logic        chk_en0;
  logic        irq;
  logic        irq0;
  int          fail_count = 0;
  int          n_checks = 0;
  // 250 MHz clock
  always #2 mclk_i = ~mclk_i;
  err_src_model u_src (.mclk_i, .ce_o(ce), .ue_o(ue), .addr_o(eaddr));
  ecc_error_report_regs u_dut (.mclk_i, .rst_n_i, .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .ce_event_i(ce),
    .ue_event_i(ue), .err_addr_i(eaddr), .check_enable_o(chk_en), .irq_o(irq));
  // build without error correction sees the same traffic
  ecc_error_report_regs #(.ECC_EN(1'b0)) u_noecc (.mclk_i, .rst_n_i, .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata0),
    .ce_event_i(ce), .ue_event_i(ue), .err_addr_i(eaddr), .check_enable_o(chk_en0),
    .irq_o(irq0));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [9:0] a, input logic [31:0] d);
    @(negedge mclk_i);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk_i);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [9:0] a, input logic [31:0] e, input string n);
    @(negedge mclk_i);
    rd = 1'b1;
    addr = a;
    @(negedge mclk_i);
    rd = 1'b0;
    chk(n, e, rdata);
    chk("noecc rdata", 32'h0, rdata0);
  endtask
  task automatic t_reset();
    rreg(OFS_STATUS, 32'h0, "status");
    rreg(OFS_IRQ_EN, 32'h0, "irq_en");
    rreg(OFS_CHECK_EN, 32'h1, "check_en");
    chk("check_o", 32'h1, {31'h0, chk_en});
    chk("noecc check_o", 32'h0, {31'h0, chk_en0});
    rreg(OFS_CE_COUNT, 32'h0, "count");
    rreg(OFS_CE_ADDR_LO, 32'h0, "addr_lo");
    $display("test reset done");
  endtask
  task automatic t_flags();
    u_src.hit(1'b0, 1'b1, 32'h0000_1000);
    rreg(OFS_STATUS, 32'h1, "status ue");
    u_src.hit(1'b1, 1'b0, 32'h1234_5678);
    rreg(OFS_STATUS, 32'h3, "status both");
    chk("irq off", 32'h0, {31'h0, irq});
    rreg(OFS_CE_ADDR_LO, 32'h1234_5678, "addr first");
    u_src.hit(1'b1, 1'b0, 32'habcd_0000);
    rreg(OFS_CE_ADDR_LO, 32'h1234_5678, "addr held");
    rreg(OFS_CE_COUNT, 32'h2, "count two");
    $display("test flags done");
  endtask
  task automatic t_clear();
    wreg(OFS_STATUS, 32'hffff_fffc);
    rreg(OFS_STATUS, 32'h3, "status w0");
    wreg(OFS_STATUS, 32'h2);
    rreg(OFS_STATUS, 32'h1, "status w1c");
    u_src.hit(1'b1, 1'b0, 32'h0000_beec);
    rreg(OFS_CE_ADDR_LO, 32'h0000_beec, "addr rearm");
    $display("test clear done");
  endtask
  task automatic t_irq();
    wreg(OFS_IRQ_EN, 32'h2);
    chk("irq ce", 32'h1, {31'h0, irq});
    wreg(OFS_STATUS, 32'h2);
    chk("irq ue masked", 32'h0, {31'h0, irq});
    wreg(OFS_IRQ_EN, 32'h1);
    chk("irq ue", 32'h1, {31'h0, irq});
    chk("noecc irq", 32'h0, {31'h0, irq0});
    rreg(OFS_IRQ_EN, 32'h1, "irq_en");
    wreg(OFS_STATUS, 32'h1);
    chk("irq clear", 32'h0, {31'h0, irq});
    $display("test irq done");
  endtask
  task automatic t_count();
    wreg(OFS_CE_COUNT, 32'h0000_00fe);
    rreg(OFS_CE_COUNT, 32'h0000_00fe, "count preset");
    repeat (3) u_src.hit(1'b1, 1'b0, 32'h0000_0c0c);
    rreg(OFS_CE_COUNT, 32'h0000_00ff, "count sat");
    fork
      wreg(OFS_CE_COUNT, 32'hffff_ff05);
      u_src.hit(1'b1, 1'b0, 32'h0000_0c0c);
    join
    rreg(OFS_CE_COUNT, 32'h0000_0005, "count load");
    $display("test count done");
  endtask
  task automatic t_off();
    wreg(OFS_CHECK_EN, 32'h0);
    chk("check_o off", 32'h0, {31'h0, chk_en});
    wreg(OFS_STATUS, 32'h3);
    u_src.hit(1'b1, 1'b1, 32'h0000_7777);
    rreg(OFS_STATUS, 32'h0, "status off");
    rreg(OFS_CE_COUNT, 32'h0000_0005, "count off");
    wreg(OFS_CHECK_EN, 32'h1);
    chk("check_o on", 32'h1, {31'h0, chk_en});
    $display("test off done");
  endtask
  task automatic t_resv();
    wreg(OFS_CE_ADDR_HI, 32'hffff_ffff);
    rreg(OFS_CE_ADDR_HI, 32'h0, "addr_hi");
    wreg(OFS_CE_ADDR_LO, 32'hffff_ffff);
    rreg(OFS_CE_ADDR_LO, 32'h0000_0c0c, "addr ro");
    wreg(10'h100, 32'hffff_ffff);
    rreg(10'h100, 32'h0, "ce data");
    rreg(10'h2c0, 32'h0, "ue addr");
    $display("test reserved done");
  endtask
  // reset in mid-run with flags, count, capture and interrupt enables non-zero and checking off
  task automatic t_rerst();
    u_src.hit(1'b1, 1'b1, 32'h0000_5555);
    wreg(OFS_IRQ_EN, 32'h3);
    chk("irq before reset", 32'h1, {31'h0, irq});
    wreg(OFS_CHECK_EN, 32'h0);
    @(negedge mclk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    chk("irq after reset", 32'h0, {31'h0, irq});
    t_reset();
    $display("test mid reset done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(negedge mclk_i);
    rst_n_i = 1'b1;
    t_reset();
    t_flags();
    t_clear();
    t_irq();
    t_count();
    t_off();
    t_resv();
    t_rerst();
    stop_test();
  end
  // watchdog, well beyond the roughly 130 cycles the tests need
  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
endmodule
